// ==== shared/mpp_pkg.sv ====
// constants and types shared by the mode and privilege protection logic
`default_nettype none
package mpp_pkg;
   // processor mode codes held in the status word
   typedef enum logic [1:0] {
      MODE_KERNEL = 2'b00,
      MODE_SUPER = 2'b01,
      MODE_BAD = 2'b10,
      MODE_USER = 2'b11
   } mpp_mode_t;

   // operations reported by the instruction sequencer
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_BUS_RESET = 3'b001,
      OP_SET_PRIO = 3'b010,
      OP_HALT = 3'b011,
      OP_TRAP_ENTRY = 3'b100,
      OP_RETURN = 3'b101,
      OP_PUSH = 3'b110,
      OP_POP = 3'b111
   } mpp_op_t;

   // page access codes
   localparam logic [1:0] ACC_NON_RES = 2'b00;
   localparam logic [1:0] ACC_READ_ONLY = 2'b01;
   localparam logic [1:0] ACC_READ_WRITE = 2'b11;

   // status word fields
   localparam int PSW_CUR_HI = 15;
   localparam int PSW_CUR_LO = 14;
   localparam int PSW_PREV_HI = 13;
   localparam int PSW_PREV_LO = 12;
   localparam int PSW_PRIO_HI = 7;
   localparam int PSW_PRIO_LO = 5;
   localparam logic [15:0] PSW_RESET = 16'h0000;

   // page map entry fields
   localparam int ENT_ACC_HI = 15;
   localparam int ENT_ACC_LO = 14;
   localparam int ENT_REL_HI = 11;
   localparam int ENT_REL_LO = 0;
   localparam int PAGE_HI = 15;
   localparam int PAGE_LO = 13;
   localparam int PAGE_OFS_W = 13;
   localparam int REL_SHIFT = 6;

   // stack adjustment in bytes
   localparam logic [15:0] SP_WORD = 16'h0002;
   localparam logic [15:0] SP_FRAME = 16'h0004;
   localparam logic [15:0] SP_RESET = 16'h0000;

   // register byte addresses
   localparam logic [11:0] REG_PSW = 12'h000;
   localparam logic [11:0] REG_SP_KERNEL = 12'h004;
   localparam logic [11:0] REG_SP_SUPER = 12'h008;
   localparam logic [11:0] REG_SP_USER = 12'h00c;
   localparam logic [11:0] REG_FAULT = 12'h010;
   localparam logic [11:0] REG_MAP_BASE = 12'h100;
   localparam int MAP_IDX_W = 6;
   localparam int FAULT_ABORT = 0;
   localparam int FAULT_NON_RES = 1;
   localparam int FAULT_PRIV = 2;
endpackage
`default_nettype wire

// ==== logic/mpp_access_check.sv ====
// checks one reference against its page access code
`timescale 1ns/10ps
`default_nettype none
module mpp_access_check (
   // reference under test
   input wire logic [1:0] accCode,
   input wire logic isWrite,
   input wire logic modeBad,
   // verdict
   output logic refused,
   output logic nonResident
);
   // missing page is detected before any relocation happens
   always_comb begin
      nonResident = (accCode != mpp_pkg::ACC_READ_ONLY) &&
                    (accCode != mpp_pkg::ACC_READ_WRITE);
      refused = nonResident || modeBad ||
                (isWrite && accCode == mpp_pkg::ACC_READ_ONLY);
   end
endmodule
`default_nettype wire

// ==== logic/mpp_mode_protect.sv ====
// processor mode protection, page access and hardware stack logic
// How it works
// - privileged control ops act only in kernel; supervisor treated like user.
// - kernel return loads previous-mode bits 13:12 from stacked status, other modes OR them with the current bits; 11 means user.
// - user references use the user map unless refPrev selects the previous-mode map from bits 13:12.
// - each page entry has an access code; read-only refuses writes.
// - codes 00 and 10 both mark a page non-resident and flag references.
// - instruction fetches use the I map, data transfers the D map.
// - bus reset and set priority outside kernel only set the privilege fault bit.
// - halt outside kernel raises a trap instead of stopping.
// - stack pointer moves by a word on each push and pop.
// - trap entry pushes status and pc on the same stack.
// - current-mode bits 15:14 choose the stack pointer, and the map unless refPrev selects previous-mode bits 13:12.
// - return reloads pc, and in kernel the whole status word, from stacked values.
`timescale 1ns/10ps
`default_nettype none
module mpp_mode_protect #(
   parameter int PHYS_W = 18
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   // classic wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [11:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAck,
   // operations from the sequencer
   input wire logic opValid,
   input wire logic [2:0] opCode,
   input wire logic [15:0] opPsw,
   input wire logic [15:0] opPc,
   // memory reference request
   input wire logic refValid,
   input wire logic [15:0] refAddr,
   input wire logic refWrite,
   input wire logic refInstr,
   input wire logic refPrev,
   // reference answer
   output logic refDone,
   output logic refAbort,
   output logic refNonRes,
   output logic [PHYS_W-1:0] refPhys,
   // control effects
   output logic busResetPulse,
   output logic haltPulse,
   output logic trapPulse,
   output logic [15:0] pswOut,
   output logic [15:0] pcOut,
   output logic [15:0] spOut,
   output logic [15:0] stackPsw,
   output logic [15:0] stackPc
);
   // stack pointer slot for a mode code, bad mode falls to user slot
   function automatic logic [1:0] spSlot(input logic [1:0] m);
      unique case (m)
         mpp_pkg::MODE_KERNEL: spSlot = 2'd0;
         mpp_pkg::MODE_SUPER: spSlot = 2'd1;
         default: spSlot = 2'd2;
      endcase
   endfunction

   // kernel test, the only mode that may use privileged ops
   function automatic logic isKernel(input logic [1:0] m);
      isKernel = (m == mpp_pkg::MODE_KERNEL);
   endfunction

   logic [15:0] pswQ, pswD, pcQ, pcD, stPswQ, stPswD, stPcQ, stPcD;
   logic [15:0] spQ [3];
   logic [15:0] spD [3];
   logic [15:0] mapQ [64];
   logic mapWe;
   logic [mpp_pkg::MAP_IDX_W-1:0] mapIdx, refIdx;
   logic [2:0] faultQ, faultD;
   logic ackQ, ackD, rstPQ, rstPD, haltQ, haltD, trapQ, trapD;
   logic doneQ, doneD, abQ, abD, nrQ, nrD;
   logic [PHYS_W-1:0] physQ, physD;
   logic [31:0] rdQ, rdD;
   logic [1:0] curMode, refMode, slot;
   logic [15:0] entry;
   logic chkRefused, chkNonRes, wbHit, kern;

   assign curMode = pswQ[mpp_pkg::PSW_CUR_HI:mpp_pkg::PSW_CUR_LO];
   assign kern = isKernel(curMode);
   assign slot = spSlot(curMode);
   assign wbHit = wbCyc && wbStb && !ackQ;
   assign mapIdx = wbAdr[7:2];

   // map selection: mode, then I or D space, then page
   always_comb begin
      refMode = refPrev ?
         pswQ[mpp_pkg::PSW_PREV_HI:mpp_pkg::PSW_PREV_LO] : curMode;
      refIdx = {refMode, refInstr ? 1'b0 : 1'b1,
                refAddr[mpp_pkg::PAGE_HI:mpp_pkg::PAGE_LO]};
   end
   assign entry = mapQ[refIdx];

   mpp_access_check u_check (
      .accCode(entry[mpp_pkg::ENT_ACC_HI:mpp_pkg::ENT_ACC_LO]),
      .isWrite(refWrite),
      .modeBad(refMode == mpp_pkg::MODE_BAD),
      .refused(chkRefused),
      .nonResident(chkNonRes)
   );

   // next state of status, stacks, references and bus slave
   always_comb begin
      pswD = pswQ;
      pcD = pcQ;
      stPswD = stPswQ;
      stPcD = stPcQ;
      spD = spQ;
      faultD = faultQ;
      rstPD = 1'b0;
      haltD = 1'b0;
      trapD = 1'b0;
      doneD = 1'b0;
      abD = abQ;
      nrD = nrQ;
      physD = physQ;
      ackD = wbHit;
      rdD = 32'h0000_0000;
      mapWe = 1'b0;
      if (opValid) begin
         unique case (mpp_pkg::mpp_op_t'(opCode))
            mpp_pkg::OP_BUS_RESET: begin
               rstPD = kern;
               faultD[mpp_pkg::FAULT_PRIV] = faultQ[mpp_pkg::FAULT_PRIV] |
                  !kern;
            end
            mpp_pkg::OP_SET_PRIO: begin
               if (kern) begin
                  pswD[mpp_pkg::PSW_PRIO_HI:mpp_pkg::PSW_PRIO_LO] =
                     opPsw[mpp_pkg::PSW_PRIO_HI:mpp_pkg::PSW_PRIO_LO];
               end
            end
            mpp_pkg::OP_HALT: begin
               haltD = kern;
               trapD = !kern;
            end
            mpp_pkg::OP_TRAP_ENTRY: begin
               // save old context on the stack of the new mode
               stPswD = pswQ;
               stPcD = pcQ;
               pswD = opPsw;
               pcD = opPc;
               spD[spSlot(opPsw[mpp_pkg::PSW_CUR_HI:mpp_pkg::PSW_CUR_LO])] =
                  spQ[spSlot(opPsw[mpp_pkg::PSW_CUR_HI:mpp_pkg::PSW_CUR_LO])]
                  - mpp_pkg::SP_FRAME;
            end
            mpp_pkg::OP_RETURN: begin
               pcD = opPc;
               spD[slot] = spQ[slot] + mpp_pkg::SP_FRAME;
               if (kern) begin
                  pswD = opPsw;
               end else begin
                  // outside kernel no privilege can be gained
                  pswD = opPsw | {pswQ[15:12], 12'h000};
                  pswD[mpp_pkg::PSW_PRIO_HI:mpp_pkg::PSW_PRIO_LO] =
                     pswQ[mpp_pkg::PSW_PRIO_HI:mpp_pkg::PSW_PRIO_LO];
               end
               pswD[mpp_pkg::PSW_PREV_HI:mpp_pkg::PSW_PREV_LO] =
                  opPsw[mpp_pkg::PSW_PREV_HI:mpp_pkg::PSW_PREV_LO] |
                  (kern ? 2'b00 :
                   pswQ[mpp_pkg::PSW_PREV_HI:mpp_pkg::PSW_PREV_LO]);
            end
            mpp_pkg::OP_PUSH: spD[slot] = spQ[slot] - mpp_pkg::SP_WORD;
            mpp_pkg::OP_POP: spD[slot] = spQ[slot] + mpp_pkg::SP_WORD;
            default: ;
         endcase
      end
      // memory reference, answered the next cycle
      if (refValid) begin
         doneD = 1'b1;
         abD = chkRefused;
         nrD = chkNonRes;
         physD = chkRefused ? '0 :
            PHYS_W'({entry[mpp_pkg::ENT_REL_HI:mpp_pkg::ENT_REL_LO],
                     {mpp_pkg::REL_SHIFT{1'b0}}} +
                    {5'h00, refAddr[mpp_pkg::PAGE_OFS_W-1:0]});
         trapD = trapD | chkRefused;
      end
      // register writes, then read data
      if (wbHit && wbWe && wbSel[0] && wbSel[1]) begin
         unique case (wbAdr)
            mpp_pkg::REG_PSW: pswD = wbDatI[15:0];
            mpp_pkg::REG_SP_KERNEL: spD[0] = wbDatI[15:0];
            mpp_pkg::REG_SP_SUPER: spD[1] = wbDatI[15:0];
            mpp_pkg::REG_SP_USER: spD[2] = wbDatI[15:0];
            mpp_pkg::REG_FAULT: faultD = faultQ & ~wbDatI[2:0];
            default: mapWe = (wbAdr[11:8] == mpp_pkg::REG_MAP_BASE[11:8]);
         endcase
      end
      // sticky faults: a new event wins over a clear
      if (refValid && chkRefused) begin
         faultD[mpp_pkg::FAULT_ABORT] = 1'b1;
      end
      if (refValid && chkNonRes) begin
         faultD[mpp_pkg::FAULT_NON_RES] = 1'b1;
      end
      if (opValid && !kern && (opCode == mpp_pkg::OP_HALT ||
          opCode == mpp_pkg::OP_SET_PRIO ||
          opCode == mpp_pkg::OP_BUS_RESET)) begin
         faultD[mpp_pkg::FAULT_PRIV] = 1'b1;
      end
      if (wbHit && !wbWe) begin
         unique case (wbAdr)
            mpp_pkg::REG_PSW: rdD = {16'h0000, pswQ};
            mpp_pkg::REG_SP_KERNEL: rdD = {16'h0000, spQ[0]};
            mpp_pkg::REG_SP_SUPER: rdD = {16'h0000, spQ[1]};
            mpp_pkg::REG_SP_USER: rdD = {16'h0000, spQ[2]};
            mpp_pkg::REG_FAULT: rdD = {29'h0000_0000, faultQ};
            default: rdD = (wbAdr[11:8] == mpp_pkg::REG_MAP_BASE[11:8]) ?
               {16'h0000, mapQ[mapIdx]} : 32'h0000_0000;
         endcase
      end
   end

   // state registers, frozen while the enable is low
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pswQ <= mpp_pkg::PSW_RESET;
         pcQ <= 16'h0000;
         stPswQ <= 16'h0000;
         stPcQ <= 16'h0000;
         spQ <= '{default: mpp_pkg::SP_RESET};
         faultQ <= 3'h0;
         ackQ <= 1'b0;
         rstPQ <= 1'b0;
         haltQ <= 1'b0;
         trapQ <= 1'b0;
         doneQ <= 1'b0;
         abQ <= 1'b0;
         nrQ <= 1'b0;
         physQ <= '0;
         rdQ <= 32'h0000_0000;
      end else if (clkEn) begin
         pswQ <= pswD;
         pcQ <= pcD;
         stPswQ <= stPswD;
         stPcQ <= stPcD;
         spQ <= spD;
         faultQ <= faultD;
         ackQ <= ackD;
         rstPQ <= rstPD;
         haltQ <= haltD;
         trapQ <= trapD;
         doneQ <= doneD;
         abQ <= abD;
         nrQ <= nrD;
         physQ <= physD;
         rdQ <= rdD;
      end
   end

   // page map store, not cleared by reset; loaded only by bus writes while the enable is high
   always_ff @(posedge sys_clk) begin
      if (clkEn && mapWe) begin
         mapQ[mapIdx] <= wbDatI[15:0];
      end
   end

   assign wbAck = ackQ;
   assign wbDatO = rdQ;
   assign refDone = doneQ;
   assign refAbort = abQ;
   assign refNonRes = nrQ;
   assign refPhys = physQ;
   assign busResetPulse = rstPQ;
   assign haltPulse = haltQ;
   assign trapPulse = trapQ;
   assign pswOut = pswQ;
   assign pcOut = pcQ;
   assign spOut = spQ[slot];
   assign stackPsw = stPswQ;
   assign stackPc = stPcQ;

   // checks on privilege, access and stack behaviour
   a_halt_kernel: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && opValid && opCode == mpp_pkg::OP_HALT && kern
      |=> haltPulse && !trapPulse) else $error("kernel halt lost");
   a_halt_trap: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && opValid && opCode == mpp_pkg::OP_HALT && !kern
      |=> trapPulse && !haltPulse) else $error("halt not trapped");
   a_reset_blocked: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && opValid && opCode == mpp_pkg::OP_BUS_RESET && !kern
      |=> !busResetPulse) else $error("bus reset outside kernel");
   a_prio_kept: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && opValid && opCode == mpp_pkg::OP_SET_PRIO && !kern && !wbHit
      |=> $stable(pswOut[7:5])) else $error("priority changed");
   a_prev_loaded: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && opValid && opCode == mpp_pkg::OP_RETURN && kern && !wbHit
      |=> pswOut[13:12] == $past(opPsw[13:12])) else $error("prev mode");
   a_ro_refused: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && refValid && refWrite &&
      entry[15:14] == mpp_pkg::ACC_READ_ONLY
      |=> refDone && refAbort && trapPulse && !refNonRes)
      else $error("read-only write passed");
   a_nonres_flag: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && refValid && entry[15:14] == mpp_pkg::ACC_NON_RES
      |=> refNonRes && refAbort && trapPulse && refPhys == '0)
      else $error("non-resident page relocated");
   a_push_word: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && opValid && opCode == mpp_pkg::OP_PUSH && !wbHit
      |=> spOut == $past(spOut) - mpp_pkg::SP_WORD)
      else $error("push step wrong");
   a_trap_frame: assert property (@(posedge sys_clk) disable iff (rst)
      clkEn && opValid && opCode == mpp_pkg::OP_TRAP_ENTRY && !wbHit
      |=> stackPc == $past(pcOut) && stackPsw == $past(pswOut))
      else $error("trap context not saved");
endmodule
`default_nettype wire

// ==== sim/mpp_mode_protect_test.sv ====
// self-checking bench for the mode and privilege protection block
`timescale 1ns/10ps
`default_nettype none
module mpp_mode_protect_test;
   // stimulus driven by the bench
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic clkEn = 1'h1;
   logic wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
   logic [11:0] wbAdr = 12'h000;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0;
   logic opValid = 1'h0;
   logic [2:0] opCode = 3'h0;
   logic [15:0] opPsw = 16'h0, opPc = 16'h0, refAddr = 16'h0;
   logic refValid = 1'h0, refWrite = 1'h0, refInstr = 1'h0, refPrev = 1'h0;
   // observed outputs
   logic [31:0] wbDatO;
   logic wbAck, refDone, refAbort, refNonRes;
   logic busResetPulse, haltPulse, trapPulse;
   logic [17:0] refPhys;
   logic [15:0] pswOut, pcOut, spOut, stackPsw, stackPc;
   int mismatches = 0;
   int n_tests = 0;
   integer seed = 32'hd20f;

   // device under test, clock enable driven by the bench
   mpp_mode_protect dut_u (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
      .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
      .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
      .opValid(opValid), .opCode(opCode), .opPsw(opPsw), .opPc(opPc),
      .refValid(refValid), .refAddr(refAddr), .refWrite(refWrite),
      .refInstr(refInstr), .refPrev(refPrev), .refDone(refDone),
      .refAbort(refAbort), .refNonRes(refNonRes), .refPhys(refPhys),
      .busResetPulse(busResetPulse), .haltPulse(haltPulse),
      .trapPulse(trapPulse), .pswOut(pswOut), .pcOut(pcOut),
      .spOut(spOut), .stackPsw(stackPsw), .stackPc(stackPc));

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   // verdict and end of run
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // one comparison, four-state exact
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // classic wishbone single cycle, waits for ack under a bound
   task automatic wb(input logic we, input logic [11:0] adr,
                     input logic [31:0] dat, output logic [31:0] rd);
      int n;
      @(posedge sys_clk);
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= 4'hf;
      wbDatI <= dat;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wbAck !== 1'h1 && n < 20);
      rd = wbDatO;
      if (n >= 20) begin
         mismatches++;
         test_done();
      end
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      wbWe <= 1'h0;
   endtask

   // one sequencer operation; results settle just after the taking edge
   task automatic op(input logic [2:0] c, input logic [15:0] p,
                     input logic [15:0] pc);
      @(posedge sys_clk);
      opValid <= 1'h1;
      opCode <= c;
      opPsw <= p;
      opPc <= pc;
      @(posedge sys_clk);
      opValid <= 1'h0;
      #1;
   endtask

   // one memory reference
   task automatic rf(input logic [15:0] a, input logic w, input logic i,
                     input logic p);
      @(posedge sys_clk);
      refValid <= 1'h1;
      refAddr <= a;
      refWrite <= w;
      refInstr <= i;
      refPrev <= p;
      @(posedge sys_clk);
      refValid <= 1'h0;
      #1;
      check(32'(refDone), 32'h1);
   endtask

   // expected physical address from relocation and virtual address
   function automatic logic [17:0] phys(input logic [11:0] rel,
                                        input logic [15:0] a);
      return {rel, 6'h0} + {5'h0, a[12:0]};
   endfunction

   // map entry address for {mode, data space, page}
   function automatic logic [11:0] madr(input logic [5:0] idx);
      return 12'h100 + {4'h0, idx, 2'h0};
   endfunction

   // main sequence
   initial begin
      logic [31:0] rd;
      logic [11:0] rel [4];
      logic [15:0] a;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      #1;
      check(32'(pswOut), 32'h0);
      check(32'(spOut), 32'h0);
      // random relocations for the kernel and user pages
      for (int k = 0; k < 4; k++) begin
         rel[k] = 12'($random(seed));
      end
      wb(1'h1, madr(6'h00), {16'h0, 4'hc, rel[0]}, rd);
      wb(1'h1, madr(6'h08), {16'h0, 4'hc, rel[1]}, rd);
      wb(1'h1, madr(6'h30), {16'h0, 4'hc, rel[2]}, rd);
      wb(1'h1, madr(6'h39), {16'h0, 4'h4, rel[3]}, rd);
      wb(1'h1, madr(6'h3a), 32'h0000_0000, rd);
      wb(1'h1, madr(6'h3b), 32'h0000_8000, rd);
      wb(1'h0, madr(6'h39), 32'h0, rd);
      check(rd, {16'h0, 4'h4, rel[3]});
      wb(1'h0, 12'h020, 32'h0, rd);
      check(rd, 32'h0);
      // kernel fetches and data at random offsets land in separate maps
      for (int k = 0; k < 4; k++) begin
         a = {3'h0, 13'($random(seed))};
         rf(a, 1'h0, 1'h1, 1'h0);
         check(32'(refPhys), 32'(phys(rel[0], a)));
         rf(a, 1'h1, 1'h0, 1'h0);
         check(32'(refPhys), 32'(phys(rel[1], a)));
         check(32'(refAbort), 32'h0);
      end
      // privileged operations take effect in kernel
      op(mpp_pkg::OP_BUS_RESET, 16'h0, 16'h0);
      check(32'(busResetPulse), 32'h1);
      op(mpp_pkg::OP_SET_PRIO, 16'h00e0, 16'h0);
      check(32'(pswOut), 32'h00e0);
      op(mpp_pkg::OP_HALT, 16'h0, 16'h0);
      check(32'(haltPulse), 32'h1);
      op(mpp_pkg::OP_PUSH, 16'h0, 16'h0);
      check(32'(spOut), 32'hfffe);
      op(mpp_pkg::OP_POP, 16'h0, 16'h0);
      check(32'(spOut), 32'h0);
      // trap entry into user mode stacks the old context
      op(mpp_pkg::OP_TRAP_ENTRY, 16'hf000, 16'h1234);
      check(32'(stackPsw), 32'h00e0);
      check(32'(stackPc), 32'h0);
      check(32'(pswOut), 32'hf000);
      check(32'(pcOut), 32'h1234);
      check(32'(spOut), 32'hfffc);
      // user references use only the user map and its access codes
      a = {3'h0, 13'($random(seed))};
      rf(a, 1'h0, 1'h1, 1'h0);
      check(32'(refPhys), 32'(phys(rel[2], a)));
      a = {3'h1, 13'($random(seed))};
      rf(a, 1'h0, 1'h0, 1'h0);
      check(32'(refPhys), 32'(phys(rel[3], a)));
      check(32'(refAbort), 32'h0);
      rf(a, 1'h1, 1'h0, 1'h0);
      check(32'(refAbort), 32'h1);
      check(32'(trapPulse), 32'h1);
      check(32'(refPhys), 32'h0);
      for (int k = 2; k < 4; k++) begin
         rf({3'(k), 13'h0040}, 1'h0, 1'h0, 1'h0);
         check(32'(refNonRes), 32'h1);
         check(32'(trapPulse), 32'h1);
      end
      // privileged operations outside kernel are blocked; halt raises a trap and all set the privilege fault
      op(mpp_pkg::OP_BUS_RESET, 16'h0, 16'h0);
      check(32'(busResetPulse), 32'h0);
      op(mpp_pkg::OP_SET_PRIO, 16'h00e0, 16'h0);
      check(32'(pswOut), 32'hf000);
      op(mpp_pkg::OP_HALT, 16'h0, 16'h0);
      check(32'(haltPulse), 32'h0);
      check(32'(trapPulse), 32'h1);
      wb(1'h0, mpp_pkg::REG_FAULT, 32'h0, rd);
      check(32'(rd[2:0]), 32'h7);
      wb(1'h1, mpp_pkg::REG_FAULT, 32'h7, rd);
      wb(1'h0, mpp_pkg::REG_FAULT, 32'h0, rd);
      check(32'(rd[2:0]), 32'h0);
      op(mpp_pkg::OP_PUSH, 16'h0, 16'h0);
      check(32'(spOut), 32'hfffa);
      // back to kernel: its own stack pointer comes back
      wb(1'h1, mpp_pkg::REG_PSW, 32'h0, rd);
      @(posedge sys_clk);
      #1;
      check(32'(spOut), 32'h0);
      // kernel return loads stacked status with previous mode user
      op(mpp_pkg::OP_RETURN, 16'h3000, 16'h0456);
      check(32'(pswOut), 32'h3000);
      check(32'(pcOut), 32'h0456);
      check(32'(spOut), 32'h0004);
      a = {3'h1, 13'($random(seed))};
      rf(a, 1'h0, 1'h0, 1'h1);
      check(32'(refPhys), 32'(phys(rel[3], a)));
      rf(a, 1'h1, 1'h0, 1'h1);
      check(32'(refAbort), 32'h1);
      // supervisor is held to the same limits as user
      wb(1'h1, mpp_pkg::REG_PSW, 32'h0000_4000, rd);
      op(mpp_pkg::OP_SET_PRIO, 16'h00e0, 16'h0);
      check(32'(pswOut), 32'h4000);
      op(mpp_pkg::OP_BUS_RESET, 16'h0, 16'h0);
      check(32'(busResetPulse), 32'h0);
      op(mpp_pkg::OP_HALT, 16'h0, 16'h0);
      check(32'(haltPulse), 32'h0);
      check(32'(trapPulse), 32'h1);
      op(mpp_pkg::OP_PUSH, 16'h0, 16'h0);
      check(32'(spOut), 32'hfffe);
      // invalid mode code: even a read/write page is refused
      wb(1'h1, madr(6'h28), {16'h0, 4'hc, rel[0]}, rd);
      wb(1'h1, mpp_pkg::REG_PSW, 32'h0000_8000, rd);
      rf(16'h0100, 1'h0, 1'h0, 1'h0);
      check(32'(refAbort), 32'h1);
      check(32'(trapPulse), 32'h1);
      // a low enable freezes the stack pointer through an operation
      @(posedge sys_clk);
      clkEn <= 1'h0;
      op(mpp_pkg::OP_POP, 16'h0, 16'h0);
      check(32'(spOut), 32'hfffa);
      @(posedge sys_clk);
      clkEn <= 1'h1;
      op(mpp_pkg::OP_POP, 16'h0, 16'h0);
      check(32'(spOut), 32'hfffc);
      // a second reset in mid-run restores kernel mode and clear state
      @(posedge sys_clk);
      rst <= 1'h1;
      @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      #1;
      check(32'(pswOut), 32'h0);
      check(32'(spOut), 32'h0);
      check(32'(stackPc), 32'h0);
      wb(1'h0, mpp_pkg::REG_FAULT, 32'h0, rd);
      check(32'(rd[2:0]), 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
